// ### dv/pfpc_prog_model.sv
// Production programmer model driving mode, data, strobe and output-enable pins.
// Assumes ready, validN and the device data bus come straight from the device.
`timescale 1ns/1ns
module pfpc_prog_model
    import pfpc_pkg::*;
(
    input logic sys_clk,
    input logic ready,
    input logic validN,
    input logic [pfpc_pkg::DATA_W-1:0] pinDataOut,
    input logic pinDataOe,
    output logic [pfpc_pkg::MODE_W-1:0] pinMode,
    output logic [pfpc_pkg::DATA_W-1:0] pinDataIn,
    output logic commandStrobeN,
    output logic outputEnableN
);
    logic [DATA_W-1:0] drvData;
    // Device wins the bus while it drives; else the programmer's value
    assign pinDataIn = pinDataOe ? pinDataOut : drvData;
    initial begin
        pinMode = MODE_DATA;
        drvData = '0;
        commandStrobeN = 1'b1;
        outputEnableN = 1'b1;
    end
    task automatic start_hs(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        while (ready !== 1'b1) @(posedge sys_clk);
        pinMode <= m;
        drvData <= d;
        @(posedge sys_clk);
        commandStrobeN <= 1'b0;
        do @(posedge sys_clk); while (ready !== 1'b0);
        // Released bus shows the inverse so stale values cannot pass
        drvData <= ~d;
    endtask
    task automatic end_hs;
        commandStrobeN <= 1'b1;
        do @(posedge sys_clk); while (ready !== 1'b1);
    endtask
    task automatic wr_hs(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] d);
        start_hs(m, d);
        end_hs();
    endtask
    task automatic rd_hs(input logic [MODE_W-1:0] m, output logic [DATA_W-1:0] d,
            output logic offered);
        start_hs(m, '0);
        outputEnableN <= 1'b0;
        offered = 1'b0;
        d = '0;
        for (int n = 0; n < 8 && !offered; n++) begin
            @(posedge sys_clk);
            if (validN === 1'b0) begin
                offered = 1'b1;
                d = pinDataOut;
            end
        end
        outputEnableN <= 1'b1;
        if (offered) begin
            do @(posedge sys_clk); while (validN !== 1'b1);
        end
        end_hs();
    endtask
endmodule // pfpc_prog_model

// ### dv/pfpc_tb_top.sv
// Self-checking bench for the programming command interpreter.
// Assumes the programmer model drives the handshake pins and this bench drives erasePin and is the APB master.
`timescale 1ns/1ns
module pfpc_tb_top;
    import pfpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [APB_AW-1:0] paddr;
    logic psel, penable, pwrite, pready, pslverr, e, ofr;
    logic [31:0] pwdata, prdata, v;
    logic [MODE_W-1:0] pinMode;
    pfpc_word_t pinDataIn, pinDataOut, w;
    logic pinDataOe, commandStrobeN, outputEnableN, erasePin, ready, validN;
    int errTotal = 0;
    int nChecks = 0;
    int cycles = 0;

    always #25 sys_clk = ~sys_clk;

    pfpc_top i_pfpc_top(.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinMode(pinMode), .pinDataIn(pinDataIn),
        .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .commandStrobeN(commandStrobeN),
        .outputEnableN(outputEnableN), .erasePin(erasePin), .ready(ready), .validN(validN));
    pfpc_prog_model i_pfpc_prog_model(.sys_clk(sys_clk), .ready(ready), .validN(validN),
        .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .pinMode(pinMode),
        .pinDataIn(pinDataIn), .commandStrobeN(commandStrobeN),
        .outputEnableN(outputEnableN));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rreg(input logic [APB_AW-1:0] a, output logic [31:0] rd);
        apb(1'b0, a, 32'h0, rd, e);
    endtask
    task automatic cmd(input pfpc_word_t op);
        i_pfpc_prog_model.wr_hs(MODE_COMMAND, op);
    endtask
    task automatic dat(input pfpc_word_t d);
        i_pfpc_prog_model.wr_hs(MODE_DATA, d);
    endtask
    task automatic get(output pfpc_word_t d);
        i_pfpc_prog_model.rd_hs(MODE_DATA, d, ofr);
    endtask
    task automatic setaddr(input logic [31:0] a);
        for (int i = 0; i < 4; i++) begin
            i_pfpc_prog_model.wr_hs(MODE_ADDR_FIRST + 4'(i), {8'h00, a[8*i +: 8]});
        end
    endtask

    task automatic t_regs;
        dat(16'hffff);
        rreg(REG_LOCK, v);
        chk(v, 32'(LOCK_RESET));
        rreg(REG_FUSE, v);
        chk(v, 32'(FUSE_RESET));
        rreg(REG_CTRL, v);
        chk(v, {31'h0, PORT_EN_RESET});
        apb(1'b0, 12'h020, 32'h0, v, e);
        chk({e, v[30:0]}, 32'h80000000);
        apb(1'b1, REG_CTRL, 32'h0, v, e);
        repeat (4) @(posedge sys_clk);
        chk(32'(ready), 32'h0);
        apb(1'b1, REG_CTRL, 32'h1, v, e);
    endtask
    task automatic t_bits;
        cmd(OP_SET_LOCK);
        dat(16'h8001);
        cmd(OP_GET_LOCK);
        get(w);
        chk(32'(w), 32'h8001);
        cmd(OP_CLEAR_LOCK);
        dat(16'h0001);
        cmd(OP_GET_LOCK);
        get(w);
        chk(32'(w), 32'h8000);
        rreg(REG_LOCK, v);
        chk(v, 32'h8000);
        cmd(OP_SET_FUSE);
        dat(16'h00f0);
        cmd(OP_CLEAR_FUSE);
        dat(16'h0030);
        cmd(OP_GET_FUSE);
        get(w);
        chk(32'(w), 32'h00c0);
        cmd(OP_GET_VERSION);
        get(w);
        chk(32'(w), 32'(VERSION_VALUE));
    endtask
    task automatic t_mem;
        cmd(OP_MEMORY_WRITE);
        setaddr(32'h12345610);
        for (int i = 0; i < 3; i++) dat(16'h5a00 + 16'(i));
        rreg(REG_ADDR, v);
        chk(v, 32'h12345613);
        cmd(OP_MEMORY_READ);
        setaddr(32'h12345610);
        for (int i = 0; i < 3; i++) begin
            get(w);
            chk(32'(w), 32'h5a00 + i);
        end
        setaddr(32'h12345611);
        get(w);
        chk(32'(w), 32'h5a01);
    endtask
    task automatic t_erase;
        cmd(OP_PAGE_WRITE_LOCK);
        setaddr(32'h00000020);
        dat(16'h1234);
        cmd(OP_ERASE_WRITE_LOCK);
        setaddr(32'h00000030);
        dat(16'h4321);
        cmd(OP_GET_LOCK);
        get(w);
        chk(32'(w), 32'h800c);
        cmd(OP_ERASE_ALL);
        dat(16'h0000);
        cmd(OP_GET_LOCK);
        get(w);
        chk(32'(w), 32'h800c);
        cmd(OP_GET_FUSE);
        get(w);
        chk(32'(w), 32'h00c0);
        cmd(OP_MEMORY_READ);
        setaddr(32'h10);
        get(w);
        chk(32'(w), 32'h5a00);
        setaddr(32'h30);
        get(w);
        chk(32'(w), 32'h4321);
        cmd(OP_CLEAR_LOCK);
        dat(16'hffff);
        cmd(OP_ERASE_ALL);
        dat(16'h0000);
        rreg(REG_LOCK, v);
        chk(v, 32'h0);
        rreg(REG_FUSE, v);
        chk(v, 32'h0);
        cmd(OP_MEMORY_READ);
        setaddr(32'h10);
        get(w);
        chk(32'(w !== 16'h5a00), 32'h1);
        setaddr(32'h30);
        get(w);
        chk(32'(w !== 16'h4321), 32'h1);
    endtask
    task automatic t_sec;
        cmd(OP_SET_FUSE);
        dat(16'h0003);
        cmd(OP_SET_SECURITY);
        dat(16'h0000);
        rreg(REG_STATUS, v);
        chk(32'(v[0]), 32'h1);
        cmd(OP_CLEAR_FUSE);
        dat(16'h0003);
        rreg(REG_FUSE, v);
        chk(v, 32'h3);
        cmd(OP_GET_VERSION);
        get(w);
        chk(32'(ofr), 32'h0);
        erasePin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(32'(ready), 32'h0);
        while (ready !== 1'b1) @(posedge sys_clk);
        erasePin <= 1'b0;
        rreg(REG_STATUS, v);
        chk(32'(v[0]), 32'h0);
        rreg(REG_FUSE, v);
        chk(v, 32'h0);
        cmd(OP_GET_VERSION);
        get(w);
        chk(32'(w), 32'(VERSION_VALUE));
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            stop_test();
        end
    end

    initial begin
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        erasePin = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_bits();
        t_mem();
        t_erase();
        t_sec();
        stop_test();
    end
endmodule // pfpc_tb_top

// ### src/pfpc_mem.sv
// Single-port word memory standing in for the flash plane.
// Assumes the owner serialises reads, writes and the erase sweep.
`timescale 1ns/1ns
module pfpc_mem
    import pfpc_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input logic wrEn,
    input logic rdEn,
    input logic [pfpc_pkg::MEM_AW-1:0] addr,
    input logic [pfpc_pkg::DATA_W-1:0] wrData,
    output logic [pfpc_pkg::DATA_W-1:0] rdData
);
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdData <= '0;
        end else if (rdEn) begin
            rdData <= mem[addr];
        end
    end
endmodule // pfpc_mem

// ### src/pfpc_pkg.sv
// Shared constants for the parallel production-programming command interpreter.
// Assumes one 20 MHz system clock and an APB master for the housekeeping registers.
package pfpc_pkg;

    localparam int DATA_W = 16;
    localparam int MODE_W = 4;
    localparam int ADDR_W = 32;
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int REGION_LSB = 4;
    localparam int APB_AW = 12;
    localparam int SYNC_W = 23;

    typedef logic [DATA_W-1:0] pfpc_word_t;

    // Mode field encodings
    localparam logic [MODE_W-1:0] MODE_DATA = 4'h0;
    localparam logic [MODE_W-1:0] MODE_COMMAND = 4'h1;
    localparam logic [MODE_W-1:0] MODE_ADDR_FIRST = 4'h2;
    localparam logic [MODE_W-1:0] MODE_ADDR_LAST = 4'h5;

    // Command opcodes carried in the command phase
    localparam pfpc_word_t OP_NONE = 16'h0000;
    localparam pfpc_word_t OP_PAGE_WRITE_LOCK = 16'h0002;
    localparam pfpc_word_t OP_ERASE_WRITE_LOCK = 16'h0004;
    localparam pfpc_word_t OP_ERASE_ALL = 16'h0008;
    localparam pfpc_word_t OP_SET_LOCK = 16'h0009;
    localparam pfpc_word_t OP_CLEAR_LOCK = 16'h000a;
    localparam pfpc_word_t OP_GET_LOCK = 16'h000b;
    localparam pfpc_word_t OP_SET_FUSE = 16'h000c;
    localparam pfpc_word_t OP_CLEAR_FUSE = 16'h000d;
    localparam pfpc_word_t OP_GET_FUSE = 16'h000e;
    localparam pfpc_word_t OP_SET_SECURITY = 16'h000f;
    localparam pfpc_word_t OP_GET_VERSION = 16'h001e;
    localparam pfpc_word_t OP_MEMORY_READ = 16'h001f;
    localparam pfpc_word_t OP_MEMORY_WRITE = 16'h0020;

    // Arbitrary interface version value
    localparam pfpc_word_t VERSION_VALUE = 16'h0001;

    // APB register offsets
    localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] REG_LOCK = 12'h008;
    localparam logic [APB_AW-1:0] REG_FUSE = 12'h00c;
    localparam logic [APB_AW-1:0] REG_ADDR = 12'h010;

    // Values after reset, then the erase sweep step and last address
    localparam logic PORT_EN_RESET = 1'b1;
    localparam pfpc_word_t LOCK_RESET = 16'h0000;
    localparam pfpc_word_t FUSE_RESET = 16'h0000;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 23'h000006;
    localparam logic [MEM_AW-1:0] ERASE_STEP = 8'h01;
    localparam logic [MEM_AW-1:0] ERASE_LAST = 8'hff;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_WAIT_OE = 3'b011,
        ST_WAIT_OE_HI = 3'b010,
        ST_WAIT_STROBE = 3'b110,
        ST_ERASE = 3'b111
    } pfpc_state_t;

endpackage

// ### src/pfpc_top.sv
// Command interpreter for the parallel production-programming port.
// Assumes an external programmer on the pins and an APB master on sys_clk.
// How it works
// - Full erase: command phase with erase opcode, then one data write of zero.
// - Any lock bit set at erase time aborts it; no word is changed.
// - A completed full erase clears every lock bit.
// - A completed full erase clears every general non-volatile bit.
// - Set-lock data mask sets lock bit n for each mask bit n.
// - Clear-lock data mask clears the selected lock bits.
// - Write-and-lock commands set the lock bit of the written region.
// - Get-lock read handshake returns the lock bits.
// - Set-fuse data mask sets general bit n for each mask bit n.
// - Clear-fuse pattern clears each general bit whose pattern bit is one.
// - Get-fuse read handshake returns the general bits.
// - Security set by data zero; afterwards every command is refused.
// - Security clears only on an erase pin event, after the erase sweep.
// - Four address bytes, least significant first, load the 32-bit address.
// - Chained memory reads return the addressed word then advance the address.
// - Chained memory writes store at the address then advance it.
// - Get-version data handshake returns the version value.
// - Strobe low latches and drops ready; strobe high lets ready return.
// - Data bus is 16 bits, mode field 4 bits.
// - A new command first completes the previous one.
`timescale 1ns/1ns
module pfpc_top
    import pfpc_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input logic [pfpc_pkg::APB_AW-1:0] paddr,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [pfpc_pkg::MODE_W-1:0] pinMode,
    input logic [pfpc_pkg::DATA_W-1:0] pinDataIn,
    output logic [pfpc_pkg::DATA_W-1:0] pinDataOut,
    output logic pinDataOe,
    input logic commandStrobeN,
    input logic outputEnableN,
    input logic erasePin,
    output logic ready,
    output logic validN
);
    import pfpc_pkg::*;

    function automatic logic isReadCmd(input pfpc_word_t cmd);
        isReadCmd = (cmd == OP_GET_LOCK) || (cmd == OP_GET_FUSE) ||
                    (cmd == OP_GET_VERSION) || (cmd == OP_MEMORY_READ);
    endfunction

    function automatic logic isWriteCmd(input pfpc_word_t cmd);
        isWriteCmd = (cmd == OP_MEMORY_WRITE) || (cmd == OP_PAGE_WRITE_LOCK) ||
                     (cmd == OP_ERASE_WRITE_LOCK);
    endfunction

    logic [SYNC_W-1:0] sync1_q, sync2_q;
    pfpc_state_t state_q;
    logic [MODE_W-1:0] mode_q;
    pfpc_word_t data_q, cmd_q, lock_q, fuse_q, dataOut_q;
    logic [ADDR_W-1:0] addr_q;
    logic [MEM_AW-1:0] erasePtr_q;
    logic secure_q, pinErase_q, eraseSeen_q, eraseReq_q, portEn_q;
    logic ready_q, validN_q, dataOe_q, pready_q, pslverr_q, addrHit;
    logic [31:0] prdata_q, rdMux;

    // Pins pass two flops before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
        end else begin
            sync1_q <= {pinMode, pinDataIn, commandStrobeN, outputEnableN, erasePin};
            sync2_q <= sync1_q;
        end
    end

    wire strobeLow = ~sync2_q[2];
    wire noeLow = ~sync2_q[1];
    wire erasePinS = sync2_q[0];
    wire [MODE_W-1:0] modeS = sync2_q[22:19];
    wire [DATA_W-1:0] dataS = sync2_q[18:3];

    wire isData = (mode_q == MODE_DATA);
    wire isCommand = (mode_q == MODE_COMMAND);
    wire isAddr = (mode_q >= MODE_ADDR_FIRST) && (mode_q <= MODE_ADDR_LAST);
    wire [1:0] byteSel = 2'(mode_q - MODE_ADDR_FIRST);
    wire execData = (state_q == ST_EXEC) && isData && !secure_q;
    wire readHs = isData && isReadCmd(cmd_q) && !secure_q;
    wire memWriteHs = execData && isWriteCmd(cmd_q);
    wire lockWrite = (cmd_q == OP_PAGE_WRITE_LOCK) || (cmd_q == OP_ERASE_WRITE_LOCK);
    wire eraseAsked = execData && (cmd_q == OP_ERASE_ALL) && (data_q == '0);
    wire startErase = eraseAsked && (lock_q == LOCK_RESET);
    wire eraseDone = (state_q == ST_ERASE) && (erasePtr_q == ERASE_LAST);
    wire [3:0] regionIdx = addr_q[MEM_AW-1:REGION_LSB];
    wire eraseRise = erasePinS && !eraseSeen_q;

    wire memWr = memWriteHs || (state_q == ST_ERASE);
    wire memRd = execData && (cmd_q == OP_MEMORY_READ);
    wire [MEM_AW-1:0] memAddr = (state_q == ST_ERASE) ? erasePtr_q : addr_q[MEM_AW-1:0];
    wire [DATA_W-1:0] memWdata = (state_q == ST_ERASE) ? '0 : data_q;
    wire [DATA_W-1:0] memRdata;

    wire [DATA_W-1:0] readValue = (cmd_q == OP_GET_LOCK) ? lock_q :
                                  (cmd_q == OP_GET_FUSE) ? fuse_q :
                                  (cmd_q == OP_GET_VERSION) ? VERSION_VALUE : memRdata;

    pfpc_mem u_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wrEn(memWr),
        .rdEn(memRd),
        .addr(memAddr),
        .wrData(memWdata),
        .rdData(memRdata)
    );

    // Erase pin event waits until the port is idle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eraseSeen_q <= 1'b0;
            eraseReq_q <= 1'b0;
        end else begin
            eraseSeen_q <= erasePinS;
            if (eraseRise) begin
                eraseReq_q <= 1'b1;
            end else if (state_q == ST_IDLE) begin
                eraseReq_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            mode_q <= MODE_DATA;
            data_q <= '0;
            cmd_q <= OP_NONE;
            addr_q <= '0;
            lock_q <= LOCK_RESET;
            fuse_q <= FUSE_RESET;
            secure_q <= 1'b0;
            erasePtr_q <= '0;
            pinErase_q <= 1'b0;
            ready_q <= 1'b0;
            validN_q <= 1'b1;
            dataOe_q <= 1'b0;
            dataOut_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (eraseReq_q) begin
                        pinErase_q <= 1'b1;
                        erasePtr_q <= '0;
                        ready_q <= 1'b0;
                        state_q <= ST_ERASE;
                    end else if (strobeLow && ready_q) begin
                        mode_q <= modeS;
                        data_q <= dataS;
                        ready_q <= 1'b0;
                        state_q <= ST_EXEC;
                    end else begin
                        ready_q <= portEn_q;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_WAIT_STROBE;
                    if (isCommand) begin
                        // Writes go straight to the plane, so nothing is left pending
                        cmd_q <= secure_q ? OP_NONE : data_q;
                    end else if (isAddr && !secure_q) begin
                        addr_q[{byteSel, 3'b000} +: 8] <= data_q[7:0];
                    end else if (startErase) begin
                        erasePtr_q <= '0;
                        state_q <= ST_ERASE;
                    end else if (readHs) begin
                        if (cmd_q == OP_MEMORY_READ) begin
                            addr_q <= addr_q + 32'h1;
                        end
                        state_q <= ST_WAIT_OE;
                    end else if (execData) begin
                        // Unknown or empty command falls through with no effect
                        case (cmd_q)
                            OP_SET_LOCK: lock_q <= lock_q | data_q;
                            OP_CLEAR_LOCK: lock_q <= lock_q & ~data_q;
                            OP_SET_FUSE: fuse_q <= fuse_q | data_q;
                            OP_CLEAR_FUSE: fuse_q <= fuse_q & ~data_q;
                            OP_SET_SECURITY: secure_q <= (data_q == '0);
                            default: begin
                            end
                        endcase
                        if (memWriteHs) begin
                            addr_q <= addr_q + 32'h1;
                            if (lockWrite) begin
                                lock_q[regionIdx] <= 1'b1;
                            end
                        end
                    end
                end
                ST_WAIT_OE: begin
                    if (noeLow) begin
                        dataOut_q <= readValue;
                        dataOe_q <= 1'b1;
                        validN_q <= 1'b0;
                        state_q <= ST_WAIT_OE_HI;
                    end
                end
                ST_WAIT_OE_HI: begin
                    if (!noeLow) begin
                        dataOe_q <= 1'b0;
                        validN_q <= 1'b1;
                        state_q <= ST_WAIT_STROBE;
                    end
                end
                ST_WAIT_STROBE: begin
                    if (!strobeLow) begin
                        ready_q <= portEn_q;
                        state_q <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    erasePtr_q <= erasePtr_q + ERASE_STEP;
                    if (eraseDone) begin
                        lock_q <= LOCK_RESET;
                        fuse_q <= FUSE_RESET;
                        if (pinErase_q) begin
                            secure_q <= 1'b0;
                            pinErase_q <= 1'b0;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_WAIT_STROBE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // APB slave: one wait state, unmapped offsets answer with an error
    always_comb begin
        rdMux = '0;
        addrHit = 1'b1;
        if (paddr == REG_CTRL) begin
            rdMux = {31'h0, portEn_q};
        end else if (paddr == REG_STATUS) begin
            rdMux = {13'h0, state_q, 15'h0, secure_q};
        end else if (paddr == REG_LOCK) begin
            rdMux = {16'h0, lock_q};
        end else if (paddr == REG_FUSE) begin
            rdMux = {16'h0, fuse_q};
        end else if (paddr == REG_ADDR) begin
            rdMux = addr_q;
        end else begin
            addrHit = 1'b0;
        end
    end

    wire apbAccess = psel && penable;
    wire apbWrite = apbAccess && pready_q && pwrite && addrHit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            portEn_q <= PORT_EN_RESET;
        end else begin
            pready_q <= apbAccess && !pready_q;
            pslverr_q <= apbAccess && !pready_q && !addrHit;
            if (apbAccess && !pready_q) begin
                prdata_q <= pwrite ? 32'h0 : rdMux;
            end
            if (apbWrite && (paddr == REG_CTRL)) begin
                portEn_q <= pwdata[0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pinDataOut = dataOut_q;
    assign pinDataOe = dataOe_q;
    assign ready = ready_q;
    assign validN = validN_q;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_erase_abort_locks: assert property (
        eraseAsked && (lock_q != '0) |=> state_q == ST_WAIT_STROBE && $stable(fuse_q)
        && $stable(lock_q)) else $error("erase ran with locks set");
    a_erase_clears_lock: assert property (
        eraseDone |=> lock_q == '0) else $error("lock bits survived erase");
    a_erase_clears_fuse: assert property (
        eraseDone |=> fuse_q == '0) else $error("general bits survived erase");
    a_set_lock_mask: assert property (
        execData && cmd_q == OP_SET_LOCK |=> lock_q == ($past(lock_q) | $past(data_q)))
        else $error("set lock mask wrong");
    a_clear_lock_mask: assert property (
        execData && cmd_q == OP_CLEAR_LOCK |=> lock_q == ($past(lock_q) & ~$past(data_q)))
        else $error("clear lock mask wrong");
    a_region_lock_set: assert property (
        memWriteHs && lockWrite |=> lock_q[$past(regionIdx)]) else $error("region not locked");
    a_get_lock_value: assert property (
        state_q == ST_WAIT_OE && noeLow && cmd_q == OP_GET_LOCK |=> dataOut_q == lock_q
        && !validN_q ##1 dataOe_q) else $error("lock status read wrong");
    a_set_fuse_mask: assert property (
        execData && cmd_q == OP_SET_FUSE |=> fuse_q == ($past(fuse_q) | $past(data_q)))
        else $error("set fuse mask wrong");
    a_clear_fuse_mask: assert property (
        execData && cmd_q == OP_CLEAR_FUSE |=> fuse_q == ($past(fuse_q) & ~$past(data_q)))
        else $error("clear fuse mask wrong");
    a_secure_refuse: assert property (
        secure_q && state_q == ST_EXEC |=> $stable(lock_q) && $stable(fuse_q)
        && $stable(addr_q) && (cmd_q == OP_NONE || !$past(isCommand)))
        else $error("command ran while secure");
    a_secure_hold: assert property (
        secure_q && !(eraseDone && pinErase_q) |=> secure_q) else $error("security dropped");
    a_read_advance: assert property (
        memRd |=> addr_q == $past(addr_q) + 32'h1 && state_q == ST_WAIT_OE)
        else $error("read address not advanced");
    a_write_advance: assert property (
        memWriteHs |=> addr_q == $past(addr_q) + 32'h1) else $error("write address stuck");
    a_version_value: assert property (
        !validN_q && cmd_q == OP_GET_VERSION |-> dataOut_q == VERSION_VALUE && dataOe_q)
        else $error("version value wrong");
    a_ready_drop: assert property (
        state_q == ST_IDLE && strobeLow && ready_q && !eraseReq_q |=> !ready_q
        && state_q == ST_EXEC) else $error("ready did not drop");
    a_ready_return: assert property (
        state_q == ST_WAIT_STROBE && !strobeLow && portEn_q |=> ready_q
        && state_q == ST_IDLE) else $error("ready did not return");
endmodule // pfpc_top
